// File: sfcu_pkg.sv
package sfcu_pkg;

	// link protocols
	typedef enum logic [1:0] {
		SFCU_EXT = 2'h0,
		SFCU_DUAL = 2'h1,
		SFCU_QUAD = 2'h2
	} sfcu_proto_t;

	// frame states, gray along opcode -> address -> dummy -> output
	typedef enum logic [2:0] {
		SFCU_IDLE = 3'h0,
		SFCU_OPC = 3'h1,
		SFCU_ADDR = 3'h3,
		SFCU_DUMMY = 3'h2,
		SFCU_READ = 3'h6,
		SFCU_WRITE = 3'h7,
		SFCU_SKIP = 3'h5
	} sfcu_state_t;

	// commands handed to the array engines
	typedef enum logic [3:0] {
		SFCU_K_NONE = 4'h0,
		SFCU_K_SE = 4'h1,
		SFCU_K_SE4 = 4'h2,
		SFCU_K_SSE4 = 4'h3,
		SFCU_K_BE = 4'h4,
		SFCU_K_RESUME = 4'h5,
		SFCU_K_SUSPEND = 4'h6,
		SFCU_K_OTP_PROG = 4'h7,
		SFCU_K_OTP_READ = 4'h8,
		SFCU_K_DPROG = 4'h9,
		SFCU_K_QPROG = 4'ha
	} sfcu_kind_t;

	typedef struct packed {
		sfcu_kind_t kind;
		logic [31:0] addr;
	} sfcu_cmd_t;

	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_RDFSR = 8'h70;
	localparam logic [7:0] OP_RDNV = 8'hb5;
	localparam logic [7:0] OP_RDV = 8'h85;
	localparam logic [7:0] OP_RDEV = 8'h65;
	localparam logic [7:0] OP_RDEA = 8'hc8;
	localparam logic [7:0] OP_SE = 8'hd8;
	localparam logic [7:0] OP_SE4 = 8'hdc;
	localparam logic [7:0] OP_SSE4 = 8'h21;
	localparam logic [7:0] OP_BE = 8'hc7;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_OTPR = 8'h4b;
	localparam logic [7:0] OP_OTPP = 8'h42;
	localparam logic [7:0] OP_EN4B = 8'hb7;
	localparam logic [7:0] OP_EX4B = 8'he9;
	localparam logic [7:0] OP_ENQ = 8'h35;
	localparam logic [7:0] OP_EXQ = 8'hf5;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_DP_A = 8'ha2;
	localparam logic [7:0] OP_DP_D = 8'hd2;
	localparam logic [7:0] OP_QP = 8'h32;
	localparam logic [7:0] OP_QP_STD = 8'h12;
	localparam logic [7:0] OP_QP_ALT = 8'h38;

	localparam int SR_WIP = 0;
	localparam int SR_WEL = 1;
	localparam int FSR_READY = 7;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [15:0] NVCR_RSVD = 16'h0010;

	localparam logic [2:0] ADDR_BYTES_STD = 3'h3;
	localparam logic [2:0] ADDR_BYTES_EXT = 3'h4;
	localparam logic [3:0] DUMMY_STD = 4'h8;
	localparam logic [3:0] DUMMY_QUAD = 4'ha;

	localparam int MCLK_MHZ = 100;
	localparam int STATUS_WRITE_CYCLE_TIME_NS = 1000;
	localparam logic [15:0] STATUS_WRITE_CYC =
		16'((STATUS_WRITE_CYCLE_TIME_NS * MCLK_MHZ + 999) / 1000);

endpackage

// File: sfcu_core.sv
`timescale 1ns/1ps
`default_nettype none

module sfcu_core (
	input wire logic mclk,
	input wire logic srst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic [3:0] serial_line_in,
	output logic [3:0] serial_line_out,
	output logic [3:0] serial_line_oe,
	input wire logic strap_reset_pin,
	input wire logic dual_sel,
	input wire logic [3:0] dummy_cfg,
	input wire logic [15:0] nvcfg,
	input wire logic [7:0] vcfg,
	input wire logic [7:0] evcfg,
	input wire logic [7:0] ext_addr,
	input wire logic [6:0] flag_bits,
	input wire logic engine_busy,
	output logic cmd_valid,
	output sfcu_pkg::sfcu_cmd_t cmd_data,
	input wire logic cmd_ready,
	output logic [7:0] status_reg,
	output logic quad_on,
	output logic four_byte_on
);

	// pin synchronisers: {strap, lines, cs_n, sclk}
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic sclk_s;
	logic csn_s;
	logic strap_s;
	logic [3:0] dq_s;
	logic sclk_d;
	logic csn_d;
	logic rise;
	logic fall;
	logic cs_up;

	always_ff @(posedge mclk) begin
		if (srst) begin
			sync1 <= 7'h02;
			sync2 <= 7'h02;
		end else begin
			sync1 <= {strap_reset_pin, serial_line_in, cs_n_pin, sclk_pin};
			sync2 <= sync1;
		end
	end

	assign {strap_s, dq_s, csn_s, sclk_s} = sync2;

	always_ff @(posedge mclk) begin
		if (srst) begin
			sclk_d <= 1'b0;
			csn_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			csn_d <= csn_s;
		end
	end

	assign rise = sclk_s & ~sclk_d & ~csn_s;
	assign fall = ~sclk_s & sclk_d & ~csn_s;
	assign cs_up = csn_s & ~csn_d;

	// variant strap caught once; the synchroniser still shows its reset value
	// for two edges after release, so the third edge is the first honest one
	logic variant;
	logic [1:0] strap_age;

	always_ff @(posedge mclk) begin
		if (srst) begin
			variant <= 1'b0;
			strap_age <= 2'h0;
		end else if (strap_age != 2'h3) begin
			strap_age <= strap_age + 2'h1;
			if (strap_age == 2'h2) begin
				variant <= strap_s;
			end
		end
	end

	sfcu_pkg::sfcu_proto_t proto;
	logic [5:0] step;
	logic [31:0] sh;
	logic [31:0] next_sh;
	logic [5:0] cnt;
	logic [5:0] next_cnt;

	always_comb begin
		proto = quad_on ? sfcu_pkg::SFCU_QUAD :
			(dual_sel ? sfcu_pkg::SFCU_DUAL : sfcu_pkg::SFCU_EXT);
		case (proto)
			sfcu_pkg::SFCU_QUAD: begin
				step = 6'h04;
				next_sh = {sh[27:0], dq_s};
			end
			sfcu_pkg::SFCU_DUAL: begin
				step = 6'h02;
				next_sh = {sh[29:0], dq_s[1:0]};
			end
			default: begin
				step = 6'h01;
				next_sh = {sh[30:0], dq_s[0]};
			end
		endcase
		next_cnt = cnt + step;
	end

	// opcode decode on the byte as it completes
	logic [7:0] ob;
	logic wip_any;
	logic spare_v;
	sfcu_pkg::sfcu_state_t d_state;
	sfcu_pkg::sfcu_kind_t d_kind;
	logic [2:0] d_abytes;
	logic [2:0] ab;
	logic d_ok;
	logic d_wel;
	logic d_var;
	logic accept;

	always_comb begin
		ob = next_sh[7:0];
		ab = four_byte_on ? sfcu_pkg::ADDR_BYTES_EXT : sfcu_pkg::ADDR_BYTES_STD;
		d_state = sfcu_pkg::SFCU_SKIP;
		d_kind = sfcu_pkg::SFCU_K_NONE;
		d_abytes = ab;
		d_ok = 1'b1;
		d_wel = 1'b0;
		d_var = 1'b0;
		case (ob)
			sfcu_pkg::OP_RDSR, sfcu_pkg::OP_RDFSR, sfcu_pkg::OP_RDNV,
			sfcu_pkg::OP_RDV, sfcu_pkg::OP_RDEV, sfcu_pkg::OP_RDEA: begin
				d_state = sfcu_pkg::SFCU_READ;
			end
			sfcu_pkg::OP_WRSR: begin
				d_state = sfcu_pkg::SFCU_WRITE;
				d_wel = 1'b1;
			end
			sfcu_pkg::OP_SE: begin
				d_state = sfcu_pkg::SFCU_ADDR;
				d_kind = sfcu_pkg::SFCU_K_SE;
				d_wel = 1'b1;
			end
			sfcu_pkg::OP_SE4, sfcu_pkg::OP_SSE4: begin
				d_state = sfcu_pkg::SFCU_ADDR;
				d_kind = (ob == sfcu_pkg::OP_SE4) ? sfcu_pkg::SFCU_K_SE4 : sfcu_pkg::SFCU_K_SSE4;
				d_abytes = sfcu_pkg::ADDR_BYTES_EXT;
				d_wel = 1'b1;
				d_var = 1'b1;
			end
			sfcu_pkg::OP_BE: begin
				d_state = sfcu_pkg::SFCU_ADDR;
				d_kind = sfcu_pkg::SFCU_K_BE;
				d_wel = 1'b1;
			end
			sfcu_pkg::OP_RESUME: begin
				d_kind = sfcu_pkg::SFCU_K_RESUME;
				d_wel = 1'b1;
			end
			sfcu_pkg::OP_SUSPEND: d_kind = sfcu_pkg::SFCU_K_SUSPEND;
			sfcu_pkg::OP_OTPP: begin
				d_state = sfcu_pkg::SFCU_ADDR;
				d_kind = sfcu_pkg::SFCU_K_OTP_PROG;
				d_wel = 1'b1;
			end
			sfcu_pkg::OP_OTPR: begin
				d_state = sfcu_pkg::SFCU_ADDR;
				d_kind = sfcu_pkg::SFCU_K_OTP_READ;
			end
			sfcu_pkg::OP_EN4B, sfcu_pkg::OP_EX4B: d_wel = ~variant;
			sfcu_pkg::OP_ENQ, sfcu_pkg::OP_EXQ: d_var = 1'b1;
			sfcu_pkg::OP_WREN, sfcu_pkg::OP_WRDI: d_ok = 1'b1;
			sfcu_pkg::OP_PP, sfcu_pkg::OP_DP_A, sfcu_pkg::OP_DP_D, sfcu_pkg::OP_QP,
			sfcu_pkg::OP_QP_STD, sfcu_pkg::OP_QP_ALT: begin
				d_state = sfcu_pkg::SFCU_ADDR;
				d_wel = 1'b1;
				if (proto == sfcu_pkg::SFCU_DUAL) begin
					d_kind = sfcu_pkg::SFCU_K_DPROG;
					d_ok = (ob == sfcu_pkg::OP_PP) || (ob == sfcu_pkg::OP_DP_A) ||
						(ob == sfcu_pkg::OP_DP_D);
				end else begin
					d_kind = sfcu_pkg::SFCU_K_QPROG;
					d_ok = (proto == sfcu_pkg::SFCU_QUAD) && ((ob == sfcu_pkg::OP_PP) ||
						(ob == sfcu_pkg::OP_QP) || (ob == (variant ?
						sfcu_pkg::OP_QP_ALT : sfcu_pkg::OP_QP_STD)));
				end
			end
			default: d_ok = 1'b0;
		endcase
		// busy device still answers register reads only
		accept = d_ok && (!d_var || variant) && (!d_wel || status_reg[sfcu_pkg::SR_WEL]) &&
			(!wip_any || d_state == sfcu_pkg::SFCU_READ) &&
			(d_kind == sfcu_pkg::SFCU_K_NONE || !spare_v);
	end

	// frame sequencer
	sfcu_pkg::sfcu_state_t state;
	sfcu_pkg::sfcu_kind_t kind;
	logic [7:0] opc;
	logic [2:0] abytes;
	logic [3:0] dcnt;
	logic [3:0] dummy;
	logic armed;
	logic wr_full;
	logic [7:0] wr_byte;
	logic push;
	sfcu_pkg::sfcu_cmd_t push_data;

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= sfcu_pkg::SFCU_IDLE;
			kind <= sfcu_pkg::SFCU_K_NONE;
			opc <= 8'h00;
			sh <= 32'h0000_0000;
			cnt <= 6'h00;
			abytes <= 3'h0;
			dcnt <= 4'h0;
			dummy <= 4'h0;
			armed <= 1'b0;
			wr_full <= 1'b0;
			wr_byte <= 8'h00;
			push <= 1'b0;
			push_data <= '0;
		end else begin
			push <= 1'b0;
			if (csn_s) begin
				// a zero-address command runs only if nothing followed its opcode
				if (cs_up && armed && kind != sfcu_pkg::SFCU_K_NONE) begin
					push <= 1'b1;
					push_data <= '{kind: kind, addr: push_data.addr};
				end
				state <= sfcu_pkg::SFCU_IDLE;
				armed <= 1'b0;
			end else begin
				case (state)
					sfcu_pkg::SFCU_IDLE: begin
						cnt <= 6'h00;
						wr_full <= 1'b0;
						state <= sfcu_pkg::SFCU_OPC;
					end
					sfcu_pkg::SFCU_OPC: if (rise) begin
						sh <= next_sh;
						cnt <= next_cnt;
						if (next_cnt == 6'h08) begin
							opc <= ob;
							cnt <= 6'h00;
							kind <= accept ? d_kind : sfcu_pkg::SFCU_K_NONE;
							abytes <= d_abytes;
							dummy <= (dummy_cfg != 4'h0) ? dummy_cfg :
								(quad_on ? sfcu_pkg::DUMMY_QUAD : sfcu_pkg::DUMMY_STD);
							armed <= accept && d_state == sfcu_pkg::SFCU_SKIP;
							state <= accept ? d_state : sfcu_pkg::SFCU_SKIP;
						end
					end
					sfcu_pkg::SFCU_ADDR: if (rise) begin
						sh <= next_sh;
						cnt <= next_cnt;
						if (next_cnt == {abytes, 3'h0}) begin
							push_data.addr <= (abytes == sfcu_pkg::ADDR_BYTES_EXT) ? next_sh :
								{ext_addr, next_sh[23:0]};
							dcnt <= 4'h0;
							state <= sfcu_pkg::SFCU_SKIP;
							if (kind == sfcu_pkg::SFCU_K_OTP_READ) begin
								state <= sfcu_pkg::SFCU_DUMMY;
							end else if (kind == sfcu_pkg::SFCU_K_SE || kind == sfcu_pkg::SFCU_K_SE4 ||
								kind == sfcu_pkg::SFCU_K_SSE4 || kind == sfcu_pkg::SFCU_K_BE) begin
								armed <= 1'b1;
							end else begin
								push <= 1'b1;
								push_data.kind <= kind;
							end
						end
					end
					sfcu_pkg::SFCU_DUMMY: if (rise) begin
						dcnt <= dcnt + 4'h1;
						if (dcnt + 4'h1 == dummy) begin
							push <= 1'b1;
							push_data.kind <= kind;
							state <= sfcu_pkg::SFCU_SKIP;
						end
					end
					sfcu_pkg::SFCU_WRITE: if (rise) begin
						sh <= next_sh;
						cnt <= {3'h0, next_cnt[2:0]};
						wr_full <= (next_cnt[2:0] == 3'h0);
						if (next_cnt[2:0] == 3'h0) begin
							wr_byte <= next_sh[7:0];
						end
					end
					sfcu_pkg::SFCU_SKIP: if (rise) begin
						armed <= 1'b0;
					end
					sfcu_pkg::SFCU_READ: armed <= 1'b0;
					default: state <= sfcu_pkg::SFCU_IDLE;
				endcase
			end
		end
	end

	// status, write enable, address mode, protocol
	logic [15:0] tmr;
	logic exec;

	assign wip_any = status_reg[sfcu_pkg::SR_WIP] | engine_busy;
	assign exec = cs_up & armed & (kind == sfcu_pkg::SFCU_K_NONE);

	always_ff @(posedge mclk) begin
		if (srst) begin
			status_reg <= sfcu_pkg::SR_RESET;
			quad_on <= 1'b0;
			four_byte_on <= 1'b0;
			tmr <= 16'h0000;
		end else begin
			if (tmr != 16'h0000) begin
				tmr <= tmr - 16'h0001;
				if (tmr == 16'h0001) begin
					status_reg[sfcu_pkg::SR_WIP] <= 1'b0;
					status_reg[sfcu_pkg::SR_WEL] <= 1'b0;
				end
			end
			// wrong framing falls through: no write, latch kept
			if (cs_up && state == sfcu_pkg::SFCU_WRITE && wr_full) begin
				status_reg[7:2] <= wr_byte[7:2];
				status_reg[sfcu_pkg::SR_WIP] <= 1'b1;
				tmr <= sfcu_pkg::STATUS_WRITE_CYC;
			end
			if (push && push_data.kind != sfcu_pkg::SFCU_K_SUSPEND &&
				push_data.kind != sfcu_pkg::SFCU_K_OTP_READ) begin
				status_reg[sfcu_pkg::SR_WEL] <= 1'b0;
			end
			if (exec) begin
				case (opc)
					sfcu_pkg::OP_WREN: status_reg[sfcu_pkg::SR_WEL] <= 1'b1;
					sfcu_pkg::OP_WRDI: status_reg[sfcu_pkg::SR_WEL] <= 1'b0;
					sfcu_pkg::OP_EN4B: four_byte_on <= 1'b1;
					sfcu_pkg::OP_EX4B: four_byte_on <= 1'b0;
					sfcu_pkg::OP_ENQ: quad_on <= 1'b1;
					sfcu_pkg::OP_EXQ: quad_on <= 1'b0;
					default: quad_on <= quad_on;
				endcase
			end
		end
	end

	// register read shifter, one byte at a time
	logic [1:0] bidx;
	logic [2:0] ocnt;
	logic [7:0] osh;
	logic [7:0] rbyte;
	logic [7:0] cur;
	logic [15:0] nv_rd;

	always_comb begin
		nv_rd = nvcfg | sfcu_pkg::NVCR_RSVD;
		case (opc)
			sfcu_pkg::OP_RDSR: rbyte = {status_reg[7:1], wip_any};
			sfcu_pkg::OP_RDFSR: rbyte = {~wip_any, flag_bits};
			sfcu_pkg::OP_RDNV: rbyte = (bidx == 2'h0) ? nv_rd[7:0] :
				((bidx == 2'h1) ? nv_rd[15:8] : 8'h00);
			sfcu_pkg::OP_RDV: rbyte = vcfg;
			sfcu_pkg::OP_RDEV: rbyte = evcfg;
			default: rbyte = ext_addr;
		endcase
		cur = (ocnt == 3'h0) ? rbyte : osh;
	end

	always_ff @(posedge mclk) begin
		if (srst || state != sfcu_pkg::SFCU_READ || csn_s) begin
			bidx <= 2'h0;
			ocnt <= 3'h0;
			osh <= 8'h00;
			serial_line_out <= 4'h0;
			serial_line_oe <= 4'h0;
		end else begin
			case (proto)
				sfcu_pkg::SFCU_QUAD: serial_line_oe <= 4'hf;
				sfcu_pkg::SFCU_DUAL: serial_line_oe <= 4'h3;
				default: serial_line_oe <= 4'h2;
			endcase
			if (fall) begin
				ocnt <= ocnt + step[2:0];
				if (ocnt == 3'h0 && bidx != 2'h3) begin
					bidx <= bidx + 2'h1;
				end
				case (proto)
					sfcu_pkg::SFCU_QUAD: begin
						serial_line_out <= cur[7:4];
						osh <= {cur[3:0], 4'h0};
					end
					sfcu_pkg::SFCU_DUAL: begin
						serial_line_out <= {2'h0, cur[7:6]};
						osh <= {cur[5:0], 2'h0};
					end
					default: begin
						serial_line_out <= {2'h0, cur[7], 1'b0};
						osh <= {cur[6:0], 1'b0};
					end
				endcase
			end
		end
	end

	// two-entry command buffer; a full buffer refuses new commands
	sfcu_pkg::sfcu_cmd_t spare;
	logic pop;

	assign pop = cmd_valid & cmd_ready;

	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_valid <= 1'b0;
			cmd_data <= '0;
			spare <= '0;
			spare_v <= 1'b0;
		end else begin
			if (push && !pop) begin
				if (!cmd_valid) begin
					cmd_data <= push_data;
					cmd_valid <= 1'b1;
				end else begin
					spare <= push_data;
					spare_v <= 1'b1;
				end
			end else if (pop && !push) begin
				if (spare_v) begin
					cmd_data <= spare;
					spare_v <= 1'b0;
				end else begin
					cmd_valid <= 1'b0;
				end
			end else if (push && pop) begin
				if (spare_v) begin
					cmd_data <= spare;
					spare <= push_data;
				end else begin
					cmd_data <= push_data;
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: sfcu_core_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sfcu_core_properties (
	input wire logic mclk,
	input wire logic srst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic [3:0] serial_line_in,
	input wire logic [3:0] serial_line_out,
	input wire logic [3:0] serial_line_oe,
	input wire logic strap_reset_pin,
	input wire logic dual_sel,
	input wire logic [3:0] dummy_cfg,
	input wire logic [15:0] nvcfg,
	input wire logic [7:0] vcfg,
	input wire logic [7:0] evcfg,
	input wire logic [7:0] ext_addr,
	input wire logic [6:0] flag_bits,
	input wire logic engine_busy,
	input wire logic cmd_valid,
	input wire sfcu_pkg::sfcu_cmd_t cmd_data,
	input wire logic cmd_ready,
	input wire logic [7:0] status_reg,
	input wire logic quad_on,
	input wire logic four_byte_on
);
	localparam int WN = int'(sfcu_pkg::STATUS_WRITE_CYC);
	logic [15:0] wip_cnt;

	always_ff @(posedge mclk) begin
		if (srst || !status_reg[0]) begin
			wip_cnt <= 16'h0000;
		end else begin
			wip_cnt <= wip_cnt + 16'h0001;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	sequence sr_update;
		$changed(status_reg[7:2]);
	endsequence
	sequence wip_start;
		$rose(status_reg[0]) ##1 status_reg[0];
	endsequence

	chk_sr_starts_wip: assert property (sr_update |-> wip_start)
		else $error("status bits changed without a timed write");
	chk_wip_length: assert property ($fell(status_reg[0]) |-> wip_cnt >= WN - 1 && wip_cnt <= WN + 1)
		else $error("write in progress length wrong");
	chk_wip_wel_drop: assert property ($fell(status_reg[0]) |-> !status_reg[1])
		else $error("write enable left set after status write");
	chk_wel_idle: assert property ($rose(status_reg[1]) |-> !status_reg[0])
		else $error("write enable set while writing");
	chk_oe_idle: assert property (cs_n_pin [*5] |-> serial_line_oe == 4'h0)
		else $error("lines driven with chip select high");
	chk_oe_width: assert property (serial_line_oe != 4'h0 |->
		serial_line_oe == (quad_on ? 4'hf : (dual_sel ? 4'h3 : 4'h2)))
		else $error("output lanes wrong for protocol");
	chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
		else $error("command dropped before taken");
	chk_push_idle: assert property ($rose(cmd_valid) |-> !status_reg[0])
		else $error("command accepted during status write");
	chk_push_wel: assert property ($rose(cmd_valid) && (cmd_data.kind == sfcu_pkg::SFCU_K_SE
		|| cmd_data.kind == sfcu_pkg::SFCU_K_BE) |-> ##[0:3] !status_reg[1])
		else $error("write enable kept after erase");
	chk_mode_cs: assert property ($changed(quad_on) || $changed(four_byte_on) |-> cs_n_pin)
		else $error("mode changed inside a frame");
	chk_quad_variant: assert property ($rose(quad_on) |-> strap_reset_pin)
		else $error("quad entered on plain variant");
endmodule

bind sfcu_core sfcu_core_properties u_props (.mclk, .srst, .sclk_pin, .cs_n_pin, .serial_line_in,
	.serial_line_out, .serial_line_oe, .strap_reset_pin, .dual_sel, .dummy_cfg, .nvcfg, .vcfg,
	.evcfg, .ext_addr, .flag_bits, .engine_busy, .cmd_valid, .cmd_data, .cmd_ready, .status_reg,
	.quad_on, .four_byte_on);

`default_nettype wire

// File: sfcu_host.sv
`timescale 1ns/1ps
`default_nettype none

module sfcu_host (
	output logic sclk,
	output logic cs_n,
	output wire logic [3:0] line,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe
);
	logic [3:0] drv = 4'h0;

	// a released lane toggles every beat, so a stale bit never reads back
	assign line = (dev_oe & dev_out) | (~dev_oe & drv);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end

	// whole beats, msb first; the serial clock rests low between frames
	task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, input int w,
		output logic [63:0] rx);
		logic [3:0] mask;
		int nt;
		mask = 4'((1 << w) - 1);
		nt = ntx / w;
		rx = 64'h0;
		cs_n = 1'b0;
		#20;
		for (int b = 0; b < nt + nrx / w; b++) begin
			if (b < nt) begin
				drv = (~drv & ~mask) | (4'(tx >> (ntx - (b + 1) * w)) & mask);
			end else begin
				drv = ~drv;
			end
			#31.25;
			if (b >= nt) begin
				rx = (rx << w) | 64'((w == 1) ? {3'h0, line[1]} : (line & mask));
			end
			sclk = 1'b1;
			#62.5;
			sclk = 1'b0;
			#31.25;
		end
		cs_n = 1'b1;
		#100;
	endtask
endmodule

`default_nettype wire

// File: tb_serial_flash_register_command_unit.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_serial_flash_register_command_unit;
	logic mclk, srst, strap, dual, busy, rdy, sclk, cs_n, cv, q_on, fb_on;
	logic [3:0] din, dout, doe, dcfg;
	logic [15:0] nv;
	logic [7:0] vc, ev, ea, sr;
	logic [6:0] fl;
	logic [63:0] rx;
	sfcu_pkg::sfcu_cmd_t cd;
	int mw;
	int mismatches = 0;
	int n_compared = 0;

	sfcu_core u_dut (.mclk(mclk), .srst(srst), .sclk_pin(sclk), .cs_n_pin(cs_n),
		.serial_line_in(din), .serial_line_out(dout), .serial_line_oe(doe),
		.strap_reset_pin(strap), .dual_sel(dual), .dummy_cfg(dcfg), .nvcfg(nv), .vcfg(vc),
		.evcfg(ev), .ext_addr(ea), .flag_bits(fl), .engine_busy(busy), .cmd_valid(cv),
		.cmd_data(cd), .cmd_ready(rdy), .status_reg(sr), .quad_on(q_on), .four_byte_on(fb_on));
	sfcu_host u_host (.sclk(sclk), .cs_n(cs_n), .line(din), .dev_out(dout), .dev_oe(doe));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic v);
		srst = 1'b1;
		strap = v;
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		repeat (6) @(negedge mclk);
	endtask

	task automatic x(input logic [63:0] tx, input int ntx, input int nrx);
		u_host.xfer(tx, ntx, nrx, mw, rx);
		@(negedge mclk);
	endtask

	task automatic take(input sfcu_pkg::sfcu_kind_t k, input logic [31:0] a, input bit ca);
		`CHK("cmd_valid", 1'b1, cv)
		`CHK("cmd_kind", k, cd.kind)
		if (ca) `CHK("cmd_addr", a, cd.addr)
		rdy = 1'b1;
		@(negedge mclk);
		rdy = 1'b0;
		@(negedge mclk);
	endtask

	task automatic t_status_write();
		x(64'h06, 8, 0);
		`CHK("wel_set", 8'h02, sr)
		x(64'h01ab, 16, 0);
		`CHK("sr_busy", 8'hab, sr)
		// host waits for the timed write before its next command
		repeat (110) @(negedge mclk);
		`CHK("sr_done", 8'ha8, sr)
		x(64'h06, 8, 0);
		x(64'h015, 12, 0);
		`CHK("sr_misframe", 8'haa, sr)
		x(64'hff, 8, 0);
		`CHK("sr_badop", 8'haa, sr)
		x(64'h04, 8, 0);
		x(64'h05, 8, 16);
		`CHK("sr_read", 16'ha8a8, rx[15:0])
	endtask

	task automatic t_reads();
		busy = 1'b1;
		x(64'h70, 8, 16);
		`CHK("fsr_busy", {2{1'b0, fl}}, rx[15:0])
		x(64'h05, 8, 8);
		`CHK("sr_busy_rd", 8'ha9, rx[7:0])
		x(64'h75, 8, 0);
		`CHK("busy_refuse", 1'b0, cv)
		busy = 1'b0;
		x(64'hb5, 8, 40);
		`CHK("nv_read", {nv[7:0] | 8'h10, nv[15:8], 8'h00}, rx[39:16])
		`CHK("nv_tail", 16'h0000, rx[15:0])
		x(64'h85, 8, 3);
		x(64'h85, 8, 16);
		`CHK("vcr_read", {2{vc}}, rx[15:0])
		x(64'h65, 8, 16);
		`CHK("evcr_read", {2{ev}}, rx[15:0])
		x(64'hc8, 8, 24);
		`CHK("ear_read", {3{ea}}, rx[23:0])
	endtask

	task automatic t_cmds();
		x({8'hd8, 24'h12_3456}, 32, 0);
		`CHK("se_no_wel", 1'b0, cv)
		x(64'h06, 8, 0);
		x({8'hd8, 24'h12_3456}, 32, 0);
		take(sfcu_pkg::SFCU_K_SE, {ea, 24'h12_3456}, 1'b1);
		x(64'h75, 8, 0);
		x(64'h75, 8, 0);
		x(64'h75, 8, 0);
		take(sfcu_pkg::SFCU_K_SUSPEND, 32'h0, 1'b0);
		take(sfcu_pkg::SFCU_K_SUSPEND, 32'h0, 1'b0);
		`CHK("buf_full", 1'b0, cv)
		x(64'h06, 8, 0);
		x(64'h7a, 8, 0);
		take(sfcu_pkg::SFCU_K_RESUME, 32'h0, 1'b0);
		x(64'h06, 8, 0);
		x({8'hc7, 24'h00_0000}, 32, 0);
		take(sfcu_pkg::SFCU_K_BE, 32'h0, 1'b0);
		x(64'h06, 8, 0);
		x({8'h42, 24'h00_0040, 8'h5a}, 40, 0);
		take(sfcu_pkg::SFCU_K_OTP_PROG, {ea, 24'h00_0040}, 1'b1);
		x({8'h4b, 24'h00_0080, 7'h00}, 39, 0);
		`CHK("otp_short", 1'b0, cv)
		x({8'h4b, 24'h00_0080, 8'h00}, 40, 0);
		take(sfcu_pkg::SFCU_K_OTP_READ, {ea, 24'h00_0080}, 1'b1);
		dcfg = 4'h2;
		x({8'h4b, 24'h00_0090}, 32, 1);
		`CHK("otp_cfg_short", 1'b0, cv)
		x({8'h4b, 24'h00_0090}, 32, 2);
		take(sfcu_pkg::SFCU_K_OTP_READ, {ea, 24'h00_0090}, 1'b1);
		dcfg = 4'h0;
		x(64'hb7, 8, 0);
		`CHK("en4_no_wel", 1'b0, fb_on)
		x(64'h06, 8, 0);
		x(64'hb7, 8, 0);
		`CHK("en4", 1'b1, fb_on)
		x(64'h06, 8, 0);
		x({8'hd8, 32'h89ab_cdef}, 40, 0);
		take(sfcu_pkg::SFCU_K_SE, 32'h89ab_cdef, 1'b1);
		x(64'h06, 8, 0);
		x(64'he9, 8, 0);
		`CHK("ex4", 1'b0, fb_on)
		x(64'h06, 8, 0);
		x(64'h35, 8, 0);
		`CHK("quad_plain", 1'b0, q_on)
		x({8'hdc, 32'h0000_1000}, 40, 0);
		`CHK("se4_plain", 1'b0, cv)
		x(64'h04, 8, 0);
	endtask

	task automatic t_dual();
		dual = 1'b1;
		mw = 2;
		x(64'h85, 8, 8);
		`CHK("dual_read", vc, rx[7:0])
		for (int i = 0; i < 3; i++) begin
			x(64'h06, 8, 0);
			x({(i == 0) ? 8'ha2 : (i == 1) ? 8'hd2 : 8'h02, 24'h00_0100}, 32, 0);
			take(sfcu_pkg::SFCU_K_DPROG, {ea, 24'h00_0100}, 1'b1);
		end
		dual = 1'b0;
		mw = 1;
	endtask

	task automatic t_variant();
		do_reset(1'b1);
		x(64'hb7, 8, 0);
		`CHK("en4_variant", 1'b1, fb_on)
		x(64'he9, 8, 0);
		x(64'h35, 8, 0);
		`CHK("quad_on", 1'b1, q_on)
		mw = 4;
		x(64'h85, 8, 8);
		`CHK("quad_read", vc, rx[7:0])
		x({8'h4b, 24'h00_0080}, 32, 36);
		`CHK("otp_q_short", 1'b0, cv)
		x({8'h4b, 24'h00_0080}, 32, 40);
		take(sfcu_pkg::SFCU_K_OTP_READ, {ea, 24'h00_0080}, 1'b1);
		x(64'h06, 8, 0);
		x({8'h38, 24'h00_0200}, 32, 0);
		take(sfcu_pkg::SFCU_K_QPROG, {ea, 24'h00_0200}, 1'b1);
		x(64'h06, 8, 0);
		x({8'h32, 24'h00_0300}, 32, 0);
		take(sfcu_pkg::SFCU_K_QPROG, {ea, 24'h00_0300}, 1'b1);
		x(64'h06, 8, 0);
		x({8'h12, 24'h00_0300}, 32, 0);
		`CHK("qp_std_off", 1'b0, cv)
		x(64'h06, 8, 0);
		x({8'hdc, 32'h0123_4567}, 40, 0);
		take(sfcu_pkg::SFCU_K_SE4, 32'h0123_4567, 1'b1);
		x(64'h06, 8, 0);
		x({8'h21, 32'h0000_2000}, 40, 0);
		take(sfcu_pkg::SFCU_K_SSE4, 32'h0000_2000, 1'b1);
		x(64'hf5, 8, 0);
		`CHK("quad_off", 1'b0, q_on)
		mw = 1;
	endtask

	initial begin
		#1_000_000;
		mismatches++;
		results();
	end

	initial begin
		srst = 1'b1;
		strap = 1'b0;
		dual = 1'b0;
		busy = 1'b0;
		rdy = 1'b0;
		dcfg = 4'h0;
		nv = 16'h1200;
		vc = 8'ha5;
		ev = 8'h3c;
		ea = 8'h81;
		fl = 7'h5a;
		mw = 1;
		do_reset(1'b0);
		t_status_write();
		t_reads();
		t_cmds();
		t_dual();
		t_variant();
		results();
	end
endmodule

`default_nettype wire
